// ### rtl/clock_controller.sv
// Clock controller: cycle-speed divider, clock gates, PLL control and AHB-Lite registers.
`timescale 1ns/1ns
`include "clkctl_defines.svh"

module clock_controller (
   // Bus clock and reset; also the oscillator clock.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Boot configuration and power reduction gating.
   input wire logic boot_double_speed_cfg,
   input wire clkctl_pkg::gate_s gate_en,
   // Feedback clock from the oscillator of the PLL, and its controls.
   input wire logic pll_feedback,
   output logic pll_up,
   output logic pll_down,
   output logic pll_run,
   // Derived clocks.
   output clkctl_pkg::clk_out_s clk_out,
   output clkctl_pkg::pll_out_s pll_out,
   output logic double_speed_bit
);
   import clkctl_pkg::*;

   logic [7:0] clock_divide_control;
   logic pll_enable;
   logic pll_reset_bit;
   logic pll_locked_flag;
   logic [1:0] feedback_divider_low;
   logic [7:0] feedback_divider_high;
   logic [6:0] reference_divider;
   logic boot_meta, boot_sync, boot_taken;
   logic [1:0] boot_stage;
   logic fb_meta, fb_sync, fb_prev;
   logic half_clk, half_phase;
   logic speed_active;
   logic [6:0] ref_cnt;
   logic [9:0] fb_cnt;
   logic ref_tick, fb_tick;
   logic [7:0] lock_cnt;
   logic [7:0] miss_cnt;
   logic [31:0] next_hrdata;
   logic dp_write;
   logic [`ADDR_W-1:0] dp_addr;
   pll_state_e pll_state, next_pll_state;

   // Bus decode.
   wire bus_take = hsel & hready & htrans[1];
   wire [`ADDR_W-1:0] word_addr = haddr[`ADDR_W-1:0];
   wire [7:0] wbyte = hwdata[7:0];
   wire wr_clkdiv = dp_write & (dp_addr == `CLKDIV_ADDR);
   wire wr_pllctl = dp_write & (dp_addr == `PLLCTL_ADDR);
   wire wr_refdiv = dp_write & (dp_addr == `REFDIV_ADDR);
   wire wr_fbdiv = dp_write & (dp_addr == `FBDIV_ADDR);
   // The shown flag drops in the cycle that the PLL stops, not one later.
   wire lock_shown = pll_locked_flag & pll_enable & ~pll_reset_bit;
   wire [7:0] pll_reg = {feedback_divider_low, 2'b00, pll_reset_bit, 1'b0,
      pll_enable, lock_shown};
   wire pll_active = pll_enable & ~pll_reset_bit;
   wire [9:0] fb_div = {feedback_divider_high, feedback_divider_low};
   wire fb_edge = fb_sync & ~fb_prev;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_comb begin
      next_hrdata = 32'h0000_0000;
      if (bus_take & ~hwrite) begin
         case (word_addr)
            `CLKDIV_ADDR: next_hrdata = {24'h00_0000, clock_divide_control};
            `PLLCTL_ADDR: next_hrdata = {24'h00_0000, pll_reg};
            `REFDIV_ADDR: next_hrdata = {25'h000_0000, reference_divider};
            `FBDIV_ADDR: next_hrdata = {24'h00_0000, feedback_divider_high};
            default: next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Read data is captured at the address phase, so it stands in the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         dp_write <= 1'b0;
         dp_addr <= '0;
      end else begin
         hrdata <= next_hrdata;
         dp_write <= bus_take & hwrite;
         dp_addr <= word_addr;
      end
   end

   // Boot strap synchroniser; the double-speed bit loads it once after reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         boot_meta <= 1'b0;
         boot_sync <= 1'b0;
         boot_stage <= 2'b00;
         fb_meta <= 1'b0;
         fb_sync <= 1'b0;
         fb_prev <= 1'b0;
      end else begin
         boot_meta <= boot_double_speed_cfg;
         boot_sync <= boot_meta;
         boot_stage <= {boot_stage[0], 1'b1};
         fb_meta <= pll_feedback;
         fb_sync <= fb_meta;
         fb_prev <= fb_sync;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clock_divide_control <= 8'h00;
         boot_taken <= 1'b0;
      end else if (!boot_taken && boot_stage[1]) begin
         boot_taken <= 1'b1;
         clock_divide_control[`BIT_DOUBLE] <= boot_sync;
      end else if (wr_clkdiv) begin
         clock_divide_control <= wbyte & `CLKDIV_WMASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_enable <= 1'b0;
         pll_reset_bit <= 1'b1;
         feedback_divider_low <= 2'b00;
         feedback_divider_high <= `FBDIV_RESET;
         reference_divider <= 7'h00;
      end else begin
         if (wr_pllctl) begin
            feedback_divider_low <= wbyte[7:6];
            pll_reset_bit <= wbyte[`BIT_PLLRST];
            pll_enable <= wbyte[`BIT_ENABLE];
         end
         if (wr_refdiv) begin
            reference_divider <= wbyte[6:0];
         end
         if (wr_fbdiv) begin
            feedback_divider_high <= wbyte;
         end
      end
   end

   // Half-rate clock; the speed select only changes while it is low and at its
   // rising point, so neither phase of the selected clock is ever shortened.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         half_phase <= 1'b0;
         half_clk <= 1'b0;
         speed_active <= 1'b0;
      end else begin
         half_phase <= ~half_phase;
         half_clk <= half_phase;
         if (half_phase) begin
            speed_active <= clock_divide_control[`BIT_DOUBLE];
         end
      end
   end

   // A plain divide-by-two flop; gating it with the oscillator would glitch.
   wire osc_half = half_clk;
   wire per_raw = speed_active ? hclk : osc_half;
   assign double_speed_bit = speed_active;

   always_comb begin
      clk_out.cpu = per_raw & gate_en.cpu;
      clk_out.per = per_raw & gate_en.per;
      clk_out.pll_ref = hclk & gate_en.pll_ref;
      clk_out.timer0 = clock_divide_control[`BIT_T0SEL] ? osc_half : clk_out.per;
      clk_out.timer1 = clock_divide_control[`BIT_T1SEL] ? osc_half : clk_out.per;
      clk_out.watchdog = clock_divide_control[`BIT_WDSEL] ? osc_half : clk_out.per;
      clk_out.card = clk_out.per;
      clk_out.adc = clk_out.per;
      clk_out.spi = clk_out.per;
      clk_out.port_sample = clk_out.per;
   end

   // Reference and feedback dividers feeding the phase detector.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_cnt <= 7'h00;
         fb_cnt <= 10'h000;
         ref_tick <= 1'b0;
         fb_tick <= 1'b0;
      end else if (!pll_active) begin
         ref_cnt <= 7'h00;
         fb_cnt <= 10'h000;
         ref_tick <= 1'b0;
         fb_tick <= 1'b0;
      end else begin
         ref_tick <= (ref_cnt == reference_divider);
         ref_cnt <= (ref_cnt == reference_divider) ? 7'h00 : ref_cnt + 7'h01;
         fb_tick <= fb_edge & (fb_cnt == fb_div);
         if (fb_edge) begin
            fb_cnt <= (fb_cnt == fb_div) ? 10'h000 : fb_cnt + 10'h001;
         end
      end
   end

   // Up when the reference leads, down when the feedback leads.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_up <= 1'b0;
         pll_down <= 1'b0;
         pll_run <= 1'b0;
         pll_state <= PLL_RESET;
         lock_cnt <= 8'h00;
         miss_cnt <= 8'h00;
         pll_locked_flag <= 1'b0;
      end else begin
         pll_up <= pll_active & ref_tick & ~fb_tick;
         pll_down <= pll_active & fb_tick & ~ref_tick;
         pll_run <= pll_active;
         pll_state <= next_pll_state;
         if (ref_tick & fb_tick) begin
            lock_cnt <= (lock_cnt == `LOCK_COUNT) ? lock_cnt : lock_cnt + 8'h01;
            miss_cnt <= 8'h00;
         end else if (ref_tick ^ fb_tick) begin
            lock_cnt <= 8'h00;
            miss_cnt <= (miss_cnt == `LOCK_LOSS) ? miss_cnt : miss_cnt + 8'h01;
         end
         if (!pll_active) begin
            lock_cnt <= 8'h00;
            miss_cnt <= 8'h00;
         end
         pll_locked_flag <= (next_pll_state == PLL_LOCKED);
      end
   end

   always_comb begin
      case (pll_state)
         PLL_RESET: next_pll_state = pll_active ? PLL_SEEK : PLL_RESET;
         PLL_SEEK: begin
            if (!pll_active) begin
               next_pll_state = PLL_RESET;
            end else if (lock_cnt == `LOCK_COUNT) begin
               next_pll_state = PLL_LOCKED;
            end else begin
               next_pll_state = PLL_SEEK;
            end
         end
         PLL_LOCKED: begin
            if (!pll_active) begin
               next_pll_state = PLL_RESET;
            end else if (miss_cnt == `LOCK_LOSS) begin
               next_pll_state = PLL_SEEK;
            end else begin
               next_pll_state = PLL_LOCKED;
            end
         end
         default: next_pll_state = PLL_RESET;
      endcase
   end

   // Downstream clocks run from the PLL only once it has locked.
   wire pll_clk = pll_feedback & pll_locked_flag;
   assign pll_out = '{decoder: pll_clk, audio: pll_clk, usb: pll_clk};
endmodule

// ### rtl/clkctl_defines.svh
// Register offsets, field positions, reset values and timing counts of the clock controller.
`ifndef CLKCTL_DEFINES_SVH
`define CLKCTL_DEFINES_SVH
`define CLKDIV_OFFSET 8'h8f
`define PLLCTL_OFFSET 8'he9
`define REFDIV_OFFSET 8'hee
`define FBDIV_OFFSET 8'hef
`define CLKDIV_ADDR 10'h23c
`define PLLCTL_ADDR 10'h3a4
`define REFDIV_ADDR 10'h3b8
`define FBDIV_ADDR 10'h3bc
`define ADDR_W 10
`define BIT_DOUBLE 0
`define BIT_T0SEL 1
`define BIT_T1SEL 2
`define BIT_WDSEL 6
`define BIT_LOCK 0
`define BIT_ENABLE 1
`define BIT_PLLRST 3
`define CLKDIV_WMASK 8'h47
`define PLLCTL_RESET 8'h08
`define REFDIV_RESET 8'h00
`define FBDIV_RESET 8'h00
`define LOCK_COUNT 8'd64
`define LOCK_LOSS 8'd8
`endif

// ### rtl/clkctl_pkg.sv
// Types shared by the clock controller.
package clkctl_pkg;
   typedef struct packed {
      logic cpu;
      logic per;
      logic pll_ref;
   } gate_s;
   typedef struct packed {
      logic cpu;
      logic per;
      logic pll_ref;
      logic watchdog;
      logic timer0;
      logic timer1;
      logic card;
      logic adc;
      logic spi;
      logic port_sample;
   } clk_out_s;
   typedef struct packed {
      logic decoder;
      logic audio;
      logic usb;
   } pll_out_s;
   typedef enum logic [2:0] {
      PLL_RESET = 3'b001,
      PLL_SEEK = 3'b010,
      PLL_LOCKED = 3'b100
   } pll_state_e;
endpackage

// ### sim/clock_controller_checker.sv
// Port assertions for the clock controller.
`timescale 1ns/1ns
module clock_controller_checker (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Gates and PLL control.
   input wire clkctl_pkg::gate_s gate_en,
   input wire logic pll_up,
   input wire logic pll_down,
   input wire logic pll_run,
   // Derived clocks.
   input wire clkctl_pkg::clk_out_s clk_out,
   input wire clkctl_pkg::pll_out_s pll_out
);
   import clkctl_pkg::*;
   logic [6:0] run_cnt;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Cycles of steady PLL run, saturating at the lock count.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) run_cnt <= 7'h00;
      else if (!pll_run) run_cnt <= 7'h00;
      else if (run_cnt != 7'h40) run_cnt <= run_cnt + 7'h01;
   end
   chk_pump_idle: assert property (!pll_run [*2] |-> !pll_up && !pll_down)
      else $error("pump pulse while stopped");
   chk_speed_pair: assert property (gate_en.cpu && gate_en.per |-> clk_out.cpu == clk_out.per)
      else $error("cpu and peripheral clocks differ");
   chk_per_family: assert property (gate_en.per |->
      {clk_out.card, clk_out.adc, clk_out.spi, clk_out.port_sample} == {4{clk_out.per}})
      else $error("derived clock differs from peripheral clock");
   chk_gate_off: assert property (!gate_en.cpu |-> !clk_out.cpu)
      else $error("gated cpu clock runs");
   chk_run_release: assert property ($rose(hresetn) |-> !pll_run [*3])
      else $error("pll runs after reset");
   chk_lock_time: assert property (pll_out != 3'b000 |-> run_cnt == 7'h40)
      else $error("pll clock before lock count");
   chk_lock_drop: assert property (!pll_run [*2] |-> pll_out == 3'b000)
      else $error("pll clock while stopped");
   chk_pll_fanout: assert property (pll_out.decoder == pll_out.audio && pll_out.audio == pll_out.usb)
      else $error("pll clocks differ");
   cover property (pll_out.decoder);
   cover property ($rose(pll_run));
   cover property (!gate_en.cpu);
endmodule

bind clock_controller clock_controller_checker chk_i (.hclk(hclk), .hresetn(hresetn),
   .gate_en(gate_en), .pll_up(pll_up), .pll_down(pll_down), .pll_run(pll_run),
   .clk_out(clk_out), .pll_out(pll_out));

// ### sim/pll_osc_model.sv
// Oscillator of the PLL, steered by the up pulses of the charge pump.
`timescale 1ns/1ns
module pll_osc_model (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Pump and run control.
   input wire logic pll_up,
   input wire logic pll_down,
   input wire logic pll_run,
   // Feedback clock.
   output logic pll_feedback
);
   int half;
   int cnt;
   int step;
   // Stands still at low while the PLL is stopped.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn || !pll_run) begin
         pll_feedback <= 1'b0;
         cnt <= 0;
         half <= 5;
      end else begin
         // An up pulse advances the phase by one cycle; the period stays fixed.
         step = (pll_up && !pll_down) ? 2 : 1;
         cnt <= (cnt + step >= half) ? cnt + step - half : cnt + step;
         if (cnt + step >= half) pll_feedback <= !pll_feedback;
      end
   end
endmodule

// ### sim/tb_clock_controller.sv
// Self-checking bench for the clock controller.
`timescale 1ns/1ns
`include "clkctl_defines.svh"
module tb_clock_controller;
   import clkctl_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, boot, fb, up, down, run, dsb, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   gate_s gate_en;
   clk_out_s clk_out;
   pll_out_s pll_out;
   int bad_count, tests_run, i, n[5];
   clock_controller uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .boot_double_speed_cfg(boot),
      .gate_en(gate_en), .pll_feedback(fb), .pll_up(up), .pll_down(down), .pll_run(run),
      .clk_out(clk_out), .pll_out(pll_out), .double_speed_bit(dsb));
   pll_osc_model osc (.hclk(hclk), .hresetn(hresetn), .pll_up(up), .pll_down(down),
      .pll_run(run), .pll_feedback(fb));
   always @(posedge clk_out.cpu) n[0]++;
   always @(posedge clk_out.per) n[1]++;
   always @(posedge clk_out.timer0) n[2]++;
   always @(posedge clk_out.timer1) n[3]++;
   always @(posedge clk_out.watchdog) n[4]++;
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   task automatic conclude();
      if (bad_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits for hreadyout; read data is taken from the cycle that the edge ends.
   task automatic wait_rdy();
      logic ok;
      for (int k = 0; k < 16; k++) begin
         @(negedge hclk);
         ok = hreadyout;
         rdq = hrdata;
         @(posedge hclk);
         if (ok === 1'b1) return;
      end
      bad_count++;
      conclude();
   endtask
   task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      wait_rdy();
   endtask
   task automatic rreg(input logic [9:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 8'h00);
      chk(rdq, exp);
   endtask
   // Counts rising edges of the cpu, peripheral, timer and watchdog clocks over 40 bus cycles.
   task automatic measure(input int c0, c1, c2, c3, c4);
      int s[5];
      repeat (4) @(negedge hclk);
      s = n;
      repeat (40) @(negedge hclk);
      chk(n[0] - s[0], c0);
      chk(n[1] - s[1], c1);
      chk(n[2] - s[2], c2);
      chk(n[3] - s[3], c3);
      chk(n[4] - s[4], c4);
      @(posedge hclk);
   endtask
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      hready = 1'b1;
      boot = 1'b1;
      gate_en = 3'b111;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      rreg(`CLKDIV_ADDR, 32'h01);
      measure(40, 40, 40, 40, 40);
      xfer(1'b1, `CLKDIV_ADDR, 8'hff);
      rreg(`CLKDIV_ADDR, 32'h47);
      measure(40, 40, 20, 20, 20);
      xfer(1'b1, `CLKDIV_ADDR, 8'h00);
      measure(20, 20, 20, 20, 20);
      chk({31'h0, dsb}, 32'h0);
      gate_en <= 3'b011;
      measure(0, 20, 20, 20, 20);
      gate_en <= 3'b111;
      rreg(`PLLCTL_ADDR, 32'h08);
      xfer(1'b1, `REFDIV_ADDR, 8'hff);
      rreg(`REFDIV_ADDR, 32'h7f);
      xfer(1'b1, `FBDIV_ADDR, 8'ha5);
      rreg(`FBDIV_ADDR, 32'ha5);
      xfer(1'b1, `FBDIV_ADDR, 8'h00);
      xfer(1'b1, `REFDIV_ADDR, 8'h13);
      xfer(1'b1, `PLLCTL_ADDR, 8'hff);
      rreg(`PLLCTL_ADDR, 32'hca);
      xfer(1'b1, `PLLCTL_ADDR, 8'h42);
      repeat (2) @(posedge hclk);
      chk({31'h0, run}, 32'h1);
      chk({31'h0, hresp}, 32'h0);
      for (i = 0; i < 3000 && rdq[0] !== 1'b1; i++) xfer(1'b0, `PLLCTL_ADDR, 8'h00);
      chk(rdq, 32'h43);
      xfer(1'b1, `PLLCTL_ADDR, 8'h4b);
      rreg(`PLLCTL_ADDR, 32'h4a);
      xfer(1'b1, 10'h000, 8'hff);
      rreg(10'h000, 32'h0);
      conclude();
   end
endmodule
